// [core/crcms_params.svh]
`ifndef CRCMS_PARAMS_SVH
`define CRCMS_PARAMS_SVH
// Notes on behaviour
// - shifter readable as high and low bytes, zero after reset, live value.
// - tap bits 15..1 select xor terms; bit 0 reads one, acts as one.
// - scanner_on set enables scanner; clear disables and resets state machine.
// - clearing scanner_on leaves all other register contents untouched.
// - with scan_run set, each engine ready causes one fetch forwarded to engine.
// - hardware clears scan_run when current address passes end and no cycle runs.
// - with irq management, scan_run reads zero during interrupt except in peek mode, stored value kept.
// - busy reads one while memory is accessed or ready pending, else zero.
// - invalid flag is read-only, resets to one, flags bad address or setup.
// - address invalid on wrap after full scan or unmapped start address.
// - burst stalls cpu; irq management pauses on interrupt, else delays it.
// - concurrent and triggered pause on interrupt only with irq management.
// - 22-bit current address loaded by software, incremented after each fetch.
// - writes to current address bytes ignored while scan_run set.
// - 22-bit end address, upper byte resets to ones, ends the scan.
// - 4-bit trigger select paces triggered mode; codes 9..15 reserved.
// - crc_shifter_run starts the serial shifter; clear turns it off.

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define CRCMS_OFS_SHIFT_HI  4'h0
`define CRCMS_OFS_SHIFT_LO  4'h1
`define CRCMS_OFS_TAPS_HI   4'h2
`define CRCMS_OFS_TAPS_LO   4'h3
`define CRCMS_OFS_SCANCTL   4'h4
`define CRCMS_OFS_CUR_U     4'h5
`define CRCMS_OFS_CUR_H     4'h6
`define CRCMS_OFS_CUR_L     4'h7
`define CRCMS_OFS_END_U     4'h8
`define CRCMS_OFS_END_H     4'h9
`define CRCMS_OFS_END_L     4'ha
`define CRCMS_OFS_TRIG      4'hb
`define CRCMS_OFS_CRCCTL    4'hc
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define CRCMS_BIT_ON        7
`define CRCMS_BIT_RUN       6
`define CRCMS_BIT_BUSY      5
`define CRCMS_BIT_INVALID   4
`define CRCMS_BIT_IRQM      3
`define CRCMS_BIT_CRC_ON    7
`define CRCMS_BIT_CRC_RUN   6
// ---------------------------------------------------------------
// reset values and limits
// ---------------------------------------------------------------
`define CRCMS_END_U_RST     6'h3f
`define CRCMS_TRIG_MAX      4'h8
`define CRCMS_FLASH_TOP     22'h01ffff
`define CRCMS_DEPTH_LOG2    4
`endif

// [core/crcms_pkg.sv]
package crcms_pkg;
  typedef enum logic [1:0] {
    CRCMS_MD_CONC  = 2'b00,
    CRCMS_MD_BURST = 2'b01,
    CRCMS_MD_PEEK  = 2'b10,
    CRCMS_MD_TRIG  = 2'b11
  } crcms_mode_t;
  typedef enum logic [1:0] {
    CRCMS_ST_IDLE  = 2'b00,
    CRCMS_ST_FETCH = 2'b01,
    CRCMS_ST_HOLD  = 2'b10
  } crcms_state_t;
endpackage

// [core/crcms_shifter.sv]
`timescale 1ns/1ns
`include "crcms_params.svh"
module crcms_shifter
  import crcms_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        sys_rst_in,
  // control
  input  wire logic        run_in,
  input  wire logic [15:0] taps_in,
  input  wire logic        load_in,
  input  wire logic [15:0] word_in,
  // state
  output logic [15:0]      shift_out,
  output logic             busy_out,
  output logic             ready_out
);
  logic [15:0] shift_ff;
  logic [15:0] acc_ff;
  logic [4:0]  cnt_ff;
  logic        fb;
  logic [15:0] nxt_acc;

  // ---------------------------------------------------------------
  // serial division, one bit per cycle
  // ---------------------------------------------------------------
  always_comb begin
    fb      = acc_ff[15] ^ shift_ff[15];
    nxt_acc = {acc_ff[14:0], 1'b0} ^ ({16{fb}} & {taps_in[15:1], 1'b1});
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      shift_ff <= 16'h0000;
      acc_ff   <= 16'h0000;
      cnt_ff   <= 5'h00;
    end else if (!run_in) begin
      cnt_ff <= 5'h00;
    end else if (load_in && cnt_ff == 5'h00) begin
      shift_ff <= word_in;
      cnt_ff   <= 5'h10;
    end else if (cnt_ff != 5'h00) begin
      acc_ff   <= nxt_acc;
      shift_ff <= {shift_ff[14:0], 1'b0};
      cnt_ff   <= cnt_ff - 5'h01;
    end
  end

  assign shift_out = shift_ff;
  assign busy_out  = (cnt_ff != 5'h00);
  // ready requests a new word only while running and idle
  assign ready_out = run_in && (cnt_ff == 5'h00);
endmodule

// [core/crcms_top.sv]
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/1ns
`include "crcms_params.svh"
module crcms_top
  import crcms_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        sys_rst_in,
  // register port
  input  wire logic [3:0]  reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic [7:0]       reg_rdata_out,
  // system
  input  wire logic        irq_active_in,
  input  wire logic [8:0]  trig_src_in,
  output logic             cpu_stall_out,
  output logic             irq_hold_out,
  // program flash
  output logic             flash_req_out,
  output logic [21:0]      flash_addr_out,
  input  wire logic        flash_ack_in,
  input  wire logic [15:0] flash_data_in,
  // crc engine status
  output logic             crc_busy_out
);
  logic [15:0]  taps_ff;
  logic         on_ff;
  logic         run_ff;
  logic         irqm_ff;
  crcms_mode_t  mode_ff;
  logic [21:0]  cur_ff;
  logic [21:0]  end_ff;
  logic [3:0]   trig_ff;
  logic         crc_on_ff;
  logic         crc_run_ff;
  logic         invalid_ff;
  logic         wrapped_ff;
  crcms_state_t st_ff;
  logic [15:0]  word_ff;
  logic [7:0]   rdata_ff;
  logic [8:0]   trig_s1_ff;
  logic [8:0]   trig_s2_ff;
  logic [8:0]   trig_s3_ff;
  logic [15:0]  shift_val;
  logic         sh_busy;
  logic         sh_ready;
  logic         run_eff;
  logic         paced;
  logic         fetch_go;
  logic         past_end;
  logic         trig_edge;
  logic         wr_cur;
  logic         busy;
  logic [21:0]  nxt_cur;

  // ---------------------------------------------------------------
  // crc shifter
  // ---------------------------------------------------------------
  crcms_shifter u_shift (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .run_in     (crc_on_ff && crc_run_ff),
    .taps_in    (taps_ff),
    .load_in    (st_ff == CRCMS_ST_HOLD),
    .word_in    (word_ff),
    .shift_out  (shift_val),
    .busy_out   (sh_busy),
    .ready_out  (sh_ready)
  );

  // ---------------------------------------------------------------
  // trigger inputs
  // ---------------------------------------------------------------
  // timers come from unrelated logic, so treat them as asynchronous
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      trig_s1_ff <= 9'h000;
      trig_s2_ff <= 9'h000;
      trig_s3_ff <= 9'h000;
    end else begin
      trig_s1_ff <= trig_src_in;
      trig_s2_ff <= trig_s1_ff;
      trig_s3_ff <= trig_s2_ff;
    end
  end

  always_comb begin
    if (trig_ff > `CRCMS_TRIG_MAX) begin
      trig_edge = 1'b0;
    end else begin
      trig_edge = trig_s2_ff[trig_ff] & ~trig_s3_ff[trig_ff];
    end
  end

  // ---------------------------------------------------------------
  // run gating by mode and interrupts
  // ---------------------------------------------------------------
  always_comb begin
    run_eff = run_ff;
    if (irqm_ff && irq_active_in && mode_ff != CRCMS_MD_PEEK) begin
      run_eff = 1'b0;
    end
    paced = (mode_ff == CRCMS_MD_TRIG) ? trig_edge : 1'b1;
  end

  assign past_end  = (cur_ff > end_ff);
  assign fetch_go  = on_ff && run_eff && sh_ready && paced && !past_end
                     && !invalid_ff && st_ff == CRCMS_ST_IDLE;
  assign busy      = (st_ff != CRCMS_ST_IDLE);
  // only writes aimed at the current address bytes count as a reload
  assign wr_cur    = reg_wr_in && !run_ff && (reg_addr_in == `CRCMS_OFS_CUR_U
                     || reg_addr_in == `CRCMS_OFS_CUR_H
                     || reg_addr_in == `CRCMS_OFS_CUR_L);

  // ---------------------------------------------------------------
  // scan state machine
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in || !on_ff) begin
      st_ff   <= CRCMS_ST_IDLE;
      word_ff <= 16'h0000;
    end else begin
      unique case (st_ff)
        CRCMS_ST_IDLE: begin
          if (fetch_go) begin
            st_ff <= CRCMS_ST_FETCH;
          end
        end
        CRCMS_ST_FETCH: begin
          if (flash_ack_in) begin
            word_ff <= flash_data_in;
            st_ff   <= CRCMS_ST_HOLD;
          end
        end
        CRCMS_ST_HOLD: begin
          // word waits here until the shifter takes it
          if (sh_ready) begin
            st_ff <= CRCMS_ST_IDLE;
          end
        end
        default: begin
          st_ff <= CRCMS_ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // current address
  // ---------------------------------------------------------------
  always_comb begin
    nxt_cur = cur_ff;
    if (wr_cur && reg_addr_in == `CRCMS_OFS_CUR_U) begin
      nxt_cur[21:16] = reg_wdata_in[5:0];
    end
    if (wr_cur && reg_addr_in == `CRCMS_OFS_CUR_H) begin
      nxt_cur[15:8] = reg_wdata_in;
    end
    if (wr_cur && reg_addr_in == `CRCMS_OFS_CUR_L) begin
      nxt_cur[7:0] = reg_wdata_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      cur_ff     <= 22'h000000;
      wrapped_ff <= 1'b0;
    end else if (st_ff == CRCMS_ST_FETCH && flash_ack_in) begin
      cur_ff <= cur_ff + 22'h000001;
      if (cur_ff == `CRCMS_FLASH_TOP) begin
        wrapped_ff <= 1'b1;
      end
    end else if (wr_cur) begin
      cur_ff     <= nxt_cur;
      wrapped_ff <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // invalid flag
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      invalid_ff <= 1'b1;
    end else if (wr_cur) begin
      // a fresh start address decides the flag on its own
      invalid_ff <= (nxt_cur > `CRCMS_FLASH_TOP);
    end else if (wrapped_ff || cur_ff > `CRCMS_FLASH_TOP) begin
      invalid_ff <= 1'b1;
    end else if (run_ff && on_ff && !(crc_on_ff && crc_run_ff)) begin
      invalid_ff <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // control and configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      on_ff   <= 1'b0;
      irqm_ff <= 1'b0;
      mode_ff <= CRCMS_MD_CONC;
    end else if (reg_wr_in && reg_addr_in == `CRCMS_OFS_SCANCTL) begin
      on_ff   <= reg_wdata_in[`CRCMS_BIT_ON];
      irqm_ff <= reg_wdata_in[`CRCMS_BIT_IRQM];
      mode_ff <= crcms_mode_t'(reg_wdata_in[1:0]);
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      run_ff <= 1'b0;
    end else if (reg_wr_in && reg_addr_in == `CRCMS_OFS_SCANCTL) begin
      run_ff <= reg_wdata_in[`CRCMS_BIT_RUN];
    end else if (past_end && !busy) begin
      run_ff <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      end_ff <= {`CRCMS_END_U_RST, 16'h0000};
    end else if (reg_wr_in && !run_ff) begin
      if (reg_addr_in == `CRCMS_OFS_END_U) begin
        end_ff[21:16] <= reg_wdata_in[5:0];
      end
      if (reg_addr_in == `CRCMS_OFS_END_H) begin
        end_ff[15:8] <= reg_wdata_in;
      end
      if (reg_addr_in == `CRCMS_OFS_END_L) begin
        end_ff[7:0] <= reg_wdata_in;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      taps_ff    <= 16'h0001;
      trig_ff    <= 4'h0;
      crc_on_ff  <= 1'b0;
      crc_run_ff <= 1'b0;
    end else if (reg_wr_in) begin
      if (reg_addr_in == `CRCMS_OFS_TAPS_HI) begin
        taps_ff[15:8] <= reg_wdata_in;
      end
      if (reg_addr_in == `CRCMS_OFS_TAPS_LO) begin
        taps_ff[7:1] <= reg_wdata_in[7:1];
      end
      if (reg_addr_in == `CRCMS_OFS_TRIG) begin
        trig_ff <= reg_wdata_in[3:0];
      end
      if (reg_addr_in == `CRCMS_OFS_CRCCTL) begin
        crc_on_ff  <= reg_wdata_in[`CRCMS_BIT_CRC_ON];
        crc_run_ff <= reg_wdata_in[`CRCMS_BIT_CRC_RUN];
      end
    end
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      rdata_ff <= 8'h00;
    end else if (reg_rd_in) begin
      unique case (reg_addr_in)
        `CRCMS_OFS_SHIFT_HI: rdata_ff <= shift_val[15:8];
        `CRCMS_OFS_SHIFT_LO: rdata_ff <= shift_val[7:0];
        `CRCMS_OFS_TAPS_HI:  rdata_ff <= taps_ff[15:8];
        `CRCMS_OFS_TAPS_LO:  rdata_ff <= {taps_ff[7:1], 1'b1};
        `CRCMS_OFS_SCANCTL:  rdata_ff <= {on_ff, run_eff, busy, invalid_ff,
                                          irqm_ff, 1'b0, mode_ff};
        `CRCMS_OFS_CUR_U:    rdata_ff <= {2'b00, cur_ff[21:16]};
        `CRCMS_OFS_CUR_H:    rdata_ff <= cur_ff[15:8];
        `CRCMS_OFS_CUR_L:    rdata_ff <= cur_ff[7:0];
        `CRCMS_OFS_END_U:    rdata_ff <= {2'b00, end_ff[21:16]};
        `CRCMS_OFS_END_H:    rdata_ff <= end_ff[15:8];
        `CRCMS_OFS_END_L:    rdata_ff <= end_ff[7:0];
        `CRCMS_OFS_TRIG:     rdata_ff <= {4'h0, trig_ff};
        `CRCMS_OFS_CRCCTL:   rdata_ff <= {crc_on_ff, crc_run_ff, sh_busy, 5'h00};
        default:             rdata_ff <= 8'h00;
      endcase
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign reg_rdata_out  = rdata_ff;
  assign flash_req_out  = (st_ff == CRCMS_ST_FETCH);
  assign flash_addr_out = cur_ff;
  assign crc_busy_out   = sh_busy;
  // burst holds the cpu while the scan lasts
  assign cpu_stall_out  = on_ff && run_eff && mode_ff == CRCMS_MD_BURST;
  // without irq management in burst the interrupt waits
  assign irq_hold_out   = cpu_stall_out && !irqm_ff && irq_active_in;
endmodule

// [verification/crc_memory_scan_control_tb_top.sv]
`timescale 1ns/1ns
`include "crcms_params.svh"
module crc_memory_scan_control_tb_top
  import crcms_pkg::*;
;
  logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, irq = 1'b0;
  logic [3:0]  addr = 4'h0, wt = 4'h0;
  logic [7:0]  wdata = 8'h00, rdata, got;
  logic [8:0]  trig = 9'h000;
  logic        stall, hold, req, ack, cbusy;
  logic [21:0] faddr, last_a;
  logic [15:0] fdata;
  int          err_total = 0, n_compared = 0, cyc = 0, fetches = 0, f0;
  localparam logic [7:0] RST_V [13] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h10, 8'h00,
    8'h00, 8'h00, 8'h3f, 8'h00, 8'h00, 8'h00, 8'h00};
  initial begin
    forever #50 clk = ~clk;
  end
  crcms_top dut (.ref_clk_in(clk), .sys_rst_in(rst), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .irq_active_in(irq), .trig_src_in(trig), .cpu_stall_out(stall),
    .irq_hold_out(hold), .flash_req_out(req), .flash_addr_out(faddr),
    .flash_ack_in(ack), .flash_data_in(fdata), .crc_busy_out(cbusy));
  crcms_flash_model flash (.ref_clk_in(clk), .wait_in(wt), .flash_req_in(req),
    .flash_addr_in(faddr), .flash_ack_out(ack), .flash_data_out(fdata));
  // ---------
  // bus tasks and checks
  // ---------
  task automatic wr8(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd8(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    got = rdata;
  endtask
  task automatic cmpv(input string nm, input logic [21:0] e, input logic [21:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chk(input string nm, input logic [3:0] a, input logic [7:0] e, m);
    rd8(a);
    cmpv(nm, 22'(e & m), 22'(got & m));
  endtask
  task automatic start(input logic [7:0] ctl);
    wr8(`CRCMS_OFS_CUR_L, 8'h10);
    wr8(`CRCMS_OFS_END_U, 8'h00);
    wr8(`CRCMS_OFS_END_L, 8'h13);
    f0 = fetches;
    wr8(`CRCMS_OFS_SCANCTL, ctl);
    wr8(`CRCMS_OFS_CUR_L, 8'h00);
  endtask
  task automatic finish();
    for (int n = 0; n < 300; n++) begin
      rd8(`CRCMS_OFS_SCANCTL);
      if (got[6] === 1'b0) break;
    end
    cmpv("fetch count", 22'h4, 22'(fetches - f0));
    cmpv("last fetch", 22'h13, last_a);
    chk("current low", `CRCMS_OFS_CUR_L, 8'h14, 8'hff);
    chk("status", `CRCMS_OFS_SCANCTL, 8'h00, 8'h70);
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ---------
  // monitor and timeout
  // ---------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    trig <= {9{cyc[3]}};
    if (req && ack) begin
      fetches <= fetches + 1;
      last_a <= faddr;
    end
    if (cyc == 20000) begin
      err_total++;
      wrap_up();
    end
  end
  // ---------
  // tests
  // ---------
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 13; i++)
      chk("reset value", 4'(i), RST_V[i], 8'hff);
    chk("unmapped", 4'hf, 8'h00, 8'hff);
    wr8(`CRCMS_OFS_TAPS_LO, 8'h00);
    chk("taps low", `CRCMS_OFS_TAPS_LO, 8'h01, 8'hff);
    wr8(`CRCMS_OFS_TAPS_HI, 8'h80);
    chk("taps high", `CRCMS_OFS_TAPS_HI, 8'h80, 8'hff);
    $display("test registers done");
    wr8(`CRCMS_OFS_CUR_L, 8'h10);
    chk("valid start", `CRCMS_OFS_SCANCTL, 8'h00, 8'h10);
    wr8(`CRCMS_OFS_SCANCTL, 8'hc0);
    chk("bad setup", `CRCMS_OFS_SCANCTL, 8'h10, 8'h10);
    wr8(`CRCMS_OFS_SCANCTL, 8'h00);
    wr8(`CRCMS_OFS_CUR_U, 8'h3f);
    chk("unmapped start", `CRCMS_OFS_SCANCTL, 8'h10, 8'h10);
    wr8(`CRCMS_OFS_CUR_U, 8'h00);
    wr8(`CRCMS_OFS_CRCCTL, 8'hc0);
    $display("test setup done");
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      wt <= 4'(k * 5);
      irq <= (crcms_mode_t'(k) == CRCMS_MD_PEEK);
      start(8'hc8 | 8'(k));
      finish();
    end
    $display("test modes done");
    @(posedge clk);
    irq <= 1'b1;
    start(8'hc8);
    repeat (60) @(posedge clk);
    cmpv("paused fetches", 22'h0, 22'(fetches - f0));
    chk("gated run", `CRCMS_OFS_SCANCTL, 8'h00, 8'h40);
    @(posedge clk);
    irq <= 1'b0;
    @(posedge clk iff (req && ack));
    repeat (3) @(negedge clk);
    cmpv("shifter busy", 22'h1, 22'(cbusy));
    finish();
    $display("test interrupt pause done");
    @(posedge clk);
    irq <= 1'b1;
    start(8'hc1);
    repeat (10) @(posedge clk);
    cmpv("stall", 22'h1, 22'(stall));
    cmpv("irq held", 22'h1, 22'(hold));
    @(posedge clk);
    irq <= 1'b0;
    finish();
    cmpv("stall end", 22'h0, 22'(stall));
    $display("test burst done");
    wr8(`CRCMS_OFS_SCANCTL, 8'h00);
    chk("end low kept", `CRCMS_OFS_END_L, 8'h13, 8'hff);
    chk("taps kept", `CRCMS_OFS_TAPS_HI, 8'h80, 8'hff);
    chk("current kept", `CRCMS_OFS_CUR_L, 8'h14, 8'hff);
    $display("test disable done");
    wrap_up();
  end
endmodule

// [verification/crcms_flash_model.sv]
`timescale 1ns/1ns
module crcms_flash_model (
  // clock and pacing
  input  wire logic        ref_clk_in,
  input  wire logic [3:0]  wait_in,
  // fetch port
  input  wire logic        flash_req_in,
  input  wire logic [21:0] flash_addr_in,
  output logic             flash_ack_out,
  output logic [15:0]      flash_data_out
);
  logic [3:0] cnt_ff = 4'h0;
  initial flash_ack_out = 1'b0;
  initial flash_data_out = 16'h0000;
  always @(posedge ref_clk_in) begin
    flash_ack_out <= 1'b0;
    // word inverted every cycle outside the ack cycle
    flash_data_out <= ~flash_data_out;
    if (flash_req_in && !flash_ack_out) begin
      if (cnt_ff >= wait_in) begin
        cnt_ff <= 4'h0;
        flash_ack_out <= 1'b1;
        flash_data_out <= flash_addr_in[15:0] ^ 16'h5a3c;
      end else begin
        cnt_ff <= cnt_ff + 4'h1;
      end
    end
  end
endmodule

// [verification/crcms_top_asserts.sv]
`timescale 1ns/1ns
`include "crcms_params.svh"
module crcms_top_asserts (
  // clock and reset
  input wire logic        ref_clk_in,
  input wire logic        sys_rst_in,
  // register port
  input wire logic [3:0]  reg_addr_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [7:0]  reg_rdata_out,
  // system and flash
  input wire logic        irq_active_in,
  input wire logic        cpu_stall_out,
  input wire logic        irq_hold_out,
  input wire logic        flash_req_out,
  input wire logic [21:0] flash_addr_out,
  input wire logic        flash_ack_in
);
  // ---------
  // helpers
  // ---------
  logic [21:0] addr_q_ff;
  logic        take;
  assign take = flash_req_out && flash_ack_in;
  always_ff @(posedge ref_clk_in) begin
    addr_q_ff <= flash_addr_out;
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  // ---------
  // properties
  // ---------
  property p_req_hold;
    flash_req_out && !flash_ack_in && !reg_wr_in && !irq_active_in |=> flash_req_out;
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("fetch dropped early");
  property p_addr_step;
    take && !reg_wr_in |=> flash_addr_out == $past(flash_addr_out) + 22'h000001;
  endproperty
  a_addr_step: assert property (p_addr_step) else $error("no step on fetch");
  property p_addr_still;
    !take && !reg_wr_in |=> $stable(flash_addr_out);
  endproperty
  a_addr_still: assert property (p_addr_still) else $error("address moved");
  property p_no_refetch;
    take |=> !flash_req_out;
  endproperty
  a_no_refetch: assert property (p_no_refetch) else $error("fetch while word held");
  property p_taps_bit0;
    reg_rd_in && reg_addr_in == `CRCMS_OFS_TAPS_LO |=> reg_rdata_out[0];
  endproperty
  a_taps_bit0: assert property (p_taps_bit0) else $error("tap bit 0 low");
  property p_cur_u;
    reg_rd_in && reg_addr_in == `CRCMS_OFS_CUR_U |=> reg_rdata_out[7:6] == 2'b00;
  endproperty
  a_cur_u: assert property (p_cur_u) else $error("upper address spare bits set");
  property p_cur_l;
    reg_rd_in && reg_addr_in == `CRCMS_OFS_CUR_L |=> reg_rdata_out == addr_q_ff[7:0];
  endproperty
  a_cur_l: assert property (p_cur_l) else $error("address read differs");
  property p_irq_hold;
    irq_hold_out |-> irq_active_in && cpu_stall_out;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt held wrongly");
  c_fetch: cover property (take);
  c_stall: cover property (cpu_stall_out);
  c_hold: cover property (irq_hold_out);
endmodule
bind crcms_top crcms_top_asserts u_asserts (
  .ref_clk_in, .sys_rst_in, .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
  .irq_active_in, .cpu_stall_out, .irq_hold_out, .flash_req_out, .flash_addr_out,
  .flash_ack_in
);
